// ### src/patsr_consts.svh
`ifndef PATSR_CONSTS_SVH
`define PATSR_CONSTS_SVH

// Register byte offsets
`define PATSR_ADDR_W        8
`define PATSR_ADDR_CTRL     8'h00
`define PATSR_ADDR_SRC      8'h04
`define PATSR_ADDR_SWC      8'h08
`define PATSR_ADDR_STAT     8'h0C

// Control register fields
`define PATSR_CTRL_T3SEL    0
`define PATSR_CTRL_MODE_LSB 1
`define PATSR_CTRL_MODE_MSB 2

// Software control register fields
`define PATSR_SWC_MODE_LSB  0
`define PATSR_SWC_MODE_MSB  5
`define PATSR_SWC_VAL_LSB   8
`define PATSR_SWC_VAL_MSB   13

// Reset values
`define PATSR_SRC_RST       6'h00
`define PATSR_SWC_RST       6'h00

// Port pin filter depth
`define PATSR_PIN_STAGES    3

`endif

// ### src/patsr_pkg.sv
package patsr_pkg;

	typedef enum logic [1:0] {
		PATSR_SRC_GEN   = 2'h0,
		PATSR_SRC_PORT  = 2'h1,
		PATSR_SRC_TIMER = 2'h2,
		PATSR_SRC_LIMIT = 2'h3
	} patsr_src_t;

	typedef enum logic [1:0] {
		PATSR_MODE_SEQ   = 2'h0,
		PATSR_MODE_PAR   = 2'h1,
		PATSR_MODE_INDEP = 2'h2,
		PATSR_MODE_RSVD  = 2'h3
	} patsr_mode_t;

endpackage : patsr_pkg

// ### src/patsr_router.sv
// What this block does
// - Modulator reload makes exactly one internal sync pulse.
// - Select bit set routes reload sync into timer channel 3 input.
// - Timer 3 drives primary converter trigger, timer 2 the secondary.
// - Sequential and parallel modes: primary trigger starts both converters.
// - Independent mode: secondary starts converter b, primary starts a.
// - Alternate source only when pair in software mode, its two mode bits and two value bits all 1.
// - Port source: pins 2, 3, 4 drive pairs 0/1, 2/3, 4/5.
// - Timer source: channels 0, 2, 3 drive pairs 0/1, 2/3, 4/5.
// - Limit source: samples 0, 1, 2 drive pairs 0/1, 2/3, 4/5.
// - Above high limit deactivates signal, below low limit activates.
`timescale 1ns/1ps
`include "patsr_consts.svh"

module patsr_router
	import patsr_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pwm_reload,
	input  wire logic [5:0]  pwm_gen,
	input  wire logic [3:0]  timer_out,
	input  wire logic        port_b_pin2,
	input  wire logic        port_b_pin3,
	input  wire logic        port_b_pin4,
	input  wire logic [2:0]  limit_high,
	input  wire logic [2:0]  limit_low,
	output logic             timer3_sync_in,
	output logic             adc_trigger_primary,
	output logic             adc_trigger_secondary,
	output logic             converter_a_start,
	output logic             converter_b_start,
	output logic      [5:0]  pwm_out
);

	localparam int PAIRS = 3;

	// Register file state
	logic              t3sel_reg;
	logic              t3sel_next;
	patsr_mode_t       mode_reg;
	patsr_mode_t       mode_next;
	logic [5:0]        src_reg;
	logic [5:0]        src_next;
	logic [5:0]        swc_mode_reg;
	logic [5:0]        swc_mode_next;
	logic [5:0]        swc_val_reg;
	logic [5:0]        swc_val_next;
	logic [31:0]       prdata_reg;
	logic [31:0]       prdata_next;
	logic              pready_reg;
	logic              pready_next;
	logic              pslverr_reg;
	logic              pslverr_next;
	logic [31:0]       rdata;
	logic              mapped;
	logic              wr_done;

	// Trigger routing state
	logic              reload_d_reg;
	logic              reload_d_next;
	logic              sync_reg;
	logic              sync_next;
	logic              t3in_reg;
	logic              t3in_next;
	logic              prim_reg;
	logic              prim_next;
	logic              sec_reg;
	logic              sec_next;
	logic              prim_d_reg;
	logic              prim_d_next;
	logic              sec_d_reg;
	logic              sec_d_next;
	logic              conv_a_reg;
	logic              conv_a_next;
	logic              conv_b_reg;
	logic              conv_b_next;

	// Waveform source state
	logic [2:0]        pin_raw;
	logic [2:0]        pin_s1_reg;
	logic [2:0]        pin_s2_reg;
	logic [2:0]        pin_s3_reg;
	logic [2:0]        pin_val_reg;
	logic [2:0]        pin_val_next;
	logic [2:0]        lim_reg;
	logic [2:0]        lim_next;
	logic [5:0]        pwm_out_reg;
	logic [5:0]        pwm_out_next;
	logic [2:0]        alt_ok;
	logic [2:0]        tmr_src;

	assign pin_raw = {port_b_pin4, port_b_pin3, port_b_pin2};
	assign tmr_src = {timer_out[3], timer_out[2], timer_out[0]};

	assign prdata                = prdata_reg;
	assign pready                = pready_reg;
	assign pslverr               = pslverr_reg;
	assign timer3_sync_in        = t3in_reg;
	assign adc_trigger_primary   = prim_reg;
	assign adc_trigger_secondary = sec_reg;
	assign converter_a_start     = conv_a_reg;
	assign converter_b_start     = conv_b_reg;
	assign pwm_out               = pwm_out_reg;

	// APB slave, one wait state per access
	always_comb begin
		mapped = 1'b1;
		rdata  = 32'h0000_0000;
		case (paddr)
			`PATSR_ADDR_CTRL: rdata[2:0] = {mode_reg, t3sel_reg};
			`PATSR_ADDR_SRC:  rdata[5:0] = src_reg;
			`PATSR_ADDR_SWC: begin
				rdata[`PATSR_SWC_MODE_MSB:`PATSR_SWC_MODE_LSB] = swc_mode_reg;
				rdata[`PATSR_SWC_VAL_MSB:`PATSR_SWC_VAL_LSB]   = swc_val_reg;
			end
			`PATSR_ADDR_STAT: rdata[16:0] = {prim_reg, sec_reg, lim_reg,
				pin_val_reg, alt_ok, pwm_out_reg};
			default: mapped = 1'b0;
		endcase
		pready_next   = psel & penable & ~pready_reg;
		prdata_next   = pready_next ? rdata : 32'h0000_0000;
		pslverr_next  = pready_next & ~mapped;
		wr_done       = psel & penable & pready_reg & pwrite;
		t3sel_next    = t3sel_reg;
		mode_next     = mode_reg;
		src_next      = src_reg;
		swc_mode_next = swc_mode_reg;
		swc_val_next  = swc_val_reg;
		if (wr_done) begin
			case (paddr)
				`PATSR_ADDR_CTRL: begin
					t3sel_next = pwdata[`PATSR_CTRL_T3SEL];
					mode_next  = patsr_mode_t'(
						pwdata[`PATSR_CTRL_MODE_MSB:`PATSR_CTRL_MODE_LSB]);
				end
				`PATSR_ADDR_SRC: src_next = pwdata[5:0];
				`PATSR_ADDR_SWC: begin
					swc_mode_next =
						pwdata[`PATSR_SWC_MODE_MSB:`PATSR_SWC_MODE_LSB];
					swc_val_next =
						pwdata[`PATSR_SWC_VAL_MSB:`PATSR_SWC_VAL_LSB];
				end
				default: t3sel_next = t3sel_reg;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t3sel_reg    <= 1'b0;
			mode_reg     <= PATSR_MODE_SEQ;
			src_reg      <= `PATSR_SRC_RST;
			swc_mode_reg <= `PATSR_SWC_RST;
			swc_val_reg  <= `PATSR_SWC_RST;
			prdata_reg   <= 32'h0000_0000;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
		end else begin
			t3sel_reg    <= t3sel_next;
			mode_reg     <= mode_next;
			src_reg      <= src_next;
			swc_mode_reg <= swc_mode_next;
			swc_val_reg  <= swc_val_next;
			prdata_reg   <= prdata_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
		end
	end

	// Sync and converter trigger routing
	always_comb begin
		reload_d_next = pwm_reload;
		sync_next     = pwm_reload & ~reload_d_reg;
		t3in_next     = t3sel_reg & sync_reg;
		prim_next     = timer_out[3];
		sec_next      = timer_out[2];
		prim_d_next   = prim_reg;
		sec_d_next    = sec_reg;
		conv_a_next   = prim_reg & ~prim_d_reg;
		if (mode_reg == PATSR_MODE_INDEP)
			conv_b_next = sec_reg & ~sec_d_reg;
		else
			conv_b_next = prim_reg & ~prim_d_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_d_reg <= 1'b0;
			sync_reg     <= 1'b0;
			t3in_reg     <= 1'b0;
			prim_reg     <= 1'b0;
			sec_reg      <= 1'b0;
			prim_d_reg   <= 1'b0;
			sec_d_reg    <= 1'b0;
			conv_a_reg   <= 1'b0;
			conv_b_reg   <= 1'b0;
		end else begin
			reload_d_reg <= reload_d_next;
			sync_reg     <= sync_next;
			t3in_reg     <= t3in_next;
			prim_reg     <= prim_next;
			sec_reg      <= sec_next;
			prim_d_reg   <= prim_d_next;
			sec_d_reg    <= sec_d_next;
			conv_a_reg   <= conv_a_next;
			conv_b_reg   <= conv_b_next;
		end
	end

	// Per-pair source selection; alternate source drives odd as complement
	for (genvar p = 0; p < PAIRS; p++) begin : g_pair
		patsr_src_t sel;
		logic       alt;
		assign sel       = patsr_src_t'(src_reg[2*p +: 2]);
		assign alt_ok[p] = &{swc_mode_reg[2*p +: 2],
			swc_val_reg[2*p +: 2]};
		always_comb begin
			alt = 1'b0;
			case (sel)
				PATSR_SRC_PORT:  alt = pin_val_reg[p];
				PATSR_SRC_TIMER: alt = tmr_src[p];
				PATSR_SRC_LIMIT: alt = lim_reg[p];
				default:         alt = 1'b0;
			endcase
			if (pin_s2_reg[p] == pin_s3_reg[p])
				pin_val_next[p] = pin_s3_reg[p];
			else
				pin_val_next[p] = pin_val_reg[p];
			if (limit_high[p])
				lim_next[p] = 1'b0;
			else if (limit_low[p])
				lim_next[p] = 1'b1;
			else
				lim_next[p] = lim_reg[p];
			if (alt_ok[p] && sel != PATSR_SRC_GEN)
				pwm_out_next[2*p +: 2] = {~alt, alt};
			else
				pwm_out_next[2*p +: 2] = pwm_gen[2*p +: 2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_reg  <= 3'h0;
			pin_s2_reg  <= 3'h0;
			pin_s3_reg  <= 3'h0;
			pin_val_reg <= 3'h0;
			lim_reg     <= 3'h0;
			pwm_out_reg <= 6'h00;
		end else begin
			pin_s1_reg  <= pin_raw;
			pin_s2_reg  <= pin_s1_reg;
			pin_s3_reg  <= pin_s2_reg;
			pin_val_reg <= pin_val_next;
			lim_reg     <= lim_next;
			pwm_out_reg <= pwm_out_next;
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_prim_rise;
		!timer_out[3] ##1 timer_out[3];
	endsequence

	sequence s_sec_rise_indep;
		!timer_out[2] ##1 (timer_out[2] && mode_reg == PATSR_MODE_INDEP)
			##1 (mode_reg == PATSR_MODE_INDEP);
	endsequence

	a_sync_one_pulse: assert property (
		pwm_reload && !reload_d_reg |=> sync_reg ##1 !sync_reg)
		else $error("reload did not give one sync pulse");

	a_t3_routed: assert property (
		sync_reg && t3sel_reg |=> timer3_sync_in)
		else $error("sync not routed to timer 3");

	a_t3_blocked: assert property (
		timer3_sync_in |-> $past(t3sel_reg) && $past(sync_reg))
		else $error("timer 3 input pulsed without select");

	a_prim_starts_a: assert property (
		s_prim_rise |=> ##1 converter_a_start)
		else $error("primary trigger did not start converter a");

	a_both_start: assert property (
		converter_a_start && $past(mode_reg) != PATSR_MODE_INDEP
			|-> converter_b_start)
		else $error("converter b not started with a");

	a_indep_b_start: assert property (
		s_sec_rise_indep |=> converter_b_start)
		else $error("secondary trigger did not start converter b");

	a_gen_default: assert property (
		!alt_ok[0] |=> pwm_out[1:0] == $past(pwm_gen[1:0]))
		else $error("pair 0 left generator without software mode");

	a_pair_compl: assert property (
		alt_ok[1] && src_reg[3:2] != PATSR_SRC_GEN
			|=> pwm_out[3] == !pwm_out[2])
		else $error("pair 1 outputs not complementary");

	a_port_pair0: assert property (
		port_b_pin2[*4] ##1 (alt_ok[0] && src_reg[1:0] == PATSR_SRC_PORT)
			|=> pwm_out[0])
		else $error("pin 2 did not drive pair 0");

	a_timer_pair2: assert property (
		alt_ok[2] && src_reg[5:4] == PATSR_SRC_TIMER
			|=> pwm_out[4] == $past(timer_out[3]))
		else $error("timer 3 did not drive pair 2");

	a_limit_off: assert property (
		limit_high[0] ##1 (alt_ok[0] && !limit_low[0]
			&& src_reg[1:0] == PATSR_SRC_LIMIT) |=> !pwm_out[0])
		else $error("high limit did not deactivate pair 0");

endmodule : patsr_router

// ### bench/patsr_periph_model.sv
`timescale 1ns/1ps
module patsr_periph_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       timer3_sync_in,
	input  wire logic       converter_a_start,
	input  wire logic       converter_b_start,
	output logic      [7:0] cnt_t3,
	output logic      [7:0] cnt_a,
	output logic      [7:0] cnt_b
);
	// Timer input and converter start event counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_t3 <= 8'h00;
			cnt_a  <= 8'h00;
			cnt_b  <= 8'h00;
		end else begin
			cnt_t3 <= cnt_t3 + {7'h00, timer3_sync_in};
			cnt_a  <= cnt_a + {7'h00, converter_a_start};
			cnt_b  <= cnt_b + {7'h00, converter_b_start};
		end
	end
endmodule : patsr_periph_model

// ### bench/pwm_adc_trigger_source_router_tb_top.sv
`timescale 1ns/1ps
`include "patsr_consts.svh"
module pwm_adc_trigger_source_router_tb_top
	import patsr_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        rld, p2, p3, p4, t3s, tpri, tsec, sa, sb, e, tv;
	logic [7:0]  paddr, c3, ca, cb, xa, xb;
	logic [31:0] pwdata, prdata, q;
	logic [5:0]  gen, pout;
	logic [3:0]  tmr;
	logic [2:0]  lh, ll;
	int          fail_count, compares;

	patsr_router dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwm_reload(rld), .pwm_gen(gen),
		.timer_out(tmr), .port_b_pin2(p2), .port_b_pin3(p3),
		.port_b_pin4(p4), .limit_high(lh), .limit_low(ll),
		.timer3_sync_in(t3s), .adc_trigger_primary(tpri),
		.adc_trigger_secondary(tsec), .converter_a_start(sa),
		.converter_b_start(sb), .pwm_out(pout));

	patsr_periph_model far (.pclk(pclk), .presetn(presetn),
		.timer3_sync_in(t3s), .converter_a_start(sa),
		.converter_b_start(sb), .cnt_t3(c3), .cnt_a(ca), .cnt_b(cb));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic give_verdict;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] x);
		compares++;
		if (s !== x) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, s);
		end
	endtask : chk

	// One APB transfer; result left in q and e
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			give_verdict();
		end
	endtask : apb

	task automatic reload_pulse;
		@(posedge pclk);
		rld <= 1'b1;
		repeat (5) @(posedge pclk);
		rld <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : reload_pulse

	// Raise one timer output, sample its trigger two cycles later
	task automatic trig(input int i);
		@(posedge pclk);
		tmr[i] <= 1'b1;
		repeat (2) @(posedge pclk);
		tv = (i == 3) ? tpri : tsec;
		tmr[i] <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : trig

	initial begin
		{presetn, psel, penable, pwrite, rld, p2, p3, p4} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		gen = 6'h15;
		tmr = 4'h0;
		{lh, ll} = 6'h00;
		{xa, xb} = 16'h0000;
		fail_count = 0;
		compares = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("pwm_out default", {26'h0, pout}, 32'h15);
		for (int a = 0; a < 12; a += 4) begin
			apb(1'b0, a[7:0], 32'h0);
			chk("reset value", q, 32'h0);
		end
		// Status shows generator waveform after reset
		apb(1'b0, `PATSR_ADDR_STAT, 32'h0);
		chk("status reset", q, 32'h15);
		apb(1'b1, 8'h10, 32'hFFFF_FFFF);
		chk("unmapped err", {31'h0, e}, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped data", q, 32'h0);
		reload_pulse();
		chk("sync blocked", {24'h0, c3}, 32'h0);
		apb(1'b1, `PATSR_ADDR_CTRL, 32'h1);
		apb(1'b0, `PATSR_ADDR_CTRL, 32'h0);
		chk("ctrl readback", q, 32'h1);
		reload_pulse();
		chk("sync routed", {24'h0, c3}, 32'h1);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, `PATSR_ADDR_CTRL, m << 1);
			trig(3);
			chk("primary trigger", {31'h0, tv}, 32'h1);
			xa++;
			if (m != 2)
				xb++;
			chk("conv a", {24'h0, ca}, {24'h0, xa});
			chk("conv b", {24'h0, cb}, {24'h0, xb});
			trig(2);
			chk("secondary trigger", {31'h0, tv}, 32'h1);
			if (m == 2)
				xb++;
			chk("conv b sec", {24'h0, cb}, {24'h0, xb});
			chk("conv a sec", {24'h0, ca}, {24'h0, xa});
		end
		apb(1'b1, `PATSR_ADDR_SWC, 32'h3F3F);
		@(posedge pclk);
		{p2, p3, p4} <= 3'b101;
		tmr <= 4'b1001;
		ll <= 3'b101;
		repeat (3) @(posedge pclk);
		ll <= 3'b000;
		for (int s = 1; s < 4; s++) begin
			apb(1'b1, `PATSR_ADDR_SRC, s * 21);
			repeat (8) @(posedge pclk);
			chk("alt source", {26'h0, pout}, 32'h19);
		end
		@(posedge pclk);
		lh <= 3'b111;
		repeat (4) @(posedge pclk);
		chk("limit high", {26'h0, pout}, 32'h2A);
		apb(1'b1, `PATSR_ADDR_SWC, 32'h3B3F);
		repeat (3) @(posedge pclk);
		chk("pair not sw", {26'h0, pout}, 32'h26);
		apb(1'b1, `PATSR_ADDR_SRC, 32'h0);
		repeat (3) @(posedge pclk);
		chk("back to gen", {26'h0, pout}, 32'h15);
		give_verdict();
	end
endmodule : pwm_adc_trigger_source_router_tb_top
